// *** bmc_map.svh ***
`ifndef BMC_MAP_SVH
`define BMC_MAP_SVH

// regulator count and field widths
`define BMC_NUM_REG        4
`define BMC_VOLT_W         5
`define BMC_MODE_W         4
`define BMC_SLOT_W         3
`define BMC_TMR_W          19
`define BMC_SEQ_W          16

// regulator indices
`define BMC_IDX_ONE_A      2'h0
`define BMC_IDX_ONE_B      2'h1
`define BMC_IDX_TWO        2'h2
`define BMC_IDX_THREE      2'h3

// set-point field selectors, also the low address bits of the store
`define BMC_FLD_ON         2'h0
`define BMC_FLD_STBY       2'h1
`define BMC_FLD_SLEEP      2'h2
`define BMC_FLD_CTRL       2'h3

// control word layout on the host write port
`define BMC_CTRL_SE_BIT    4

// valid voltage bits per regulator
`define BMC_MASK_ONE       5'h1f
`define BMC_MASK_TWO       5'h07
`define BMC_MASK_THREE     5'h0f

// switching mode codes
`define BMC_MODE_OFF       4'h0
`define BMC_MODE_PWM_OFF   4'h1
`define BMC_MODE_PFM_OFF   4'h3
`define BMC_MODE_APS_OFF   4'h4
`define BMC_MODE_PWM_PWM   4'h5
`define BMC_MODE_PWM_APS   4'h6
`define BMC_MODE_APS_APS   4'h8
`define BMC_MODE_APS_PFM   4'hc
`define BMC_MODE_PWM_PFM   4'hd
`define BMC_MODE_RESET     4'h8

// timing
`define BMC_CLK_MHZ        100
`define BMC_SETTLE_TIME_US 3000
`define BMC_SETTLE_CYCLES  (`BMC_SETTLE_TIME_US * `BMC_CLK_MHZ)
`define BMC_SS_PFM_CYCLES  32
`define BMC_SEQ_STEP       64

// loader walks every store address once
`define BMC_LOAD_LAST      5'h10

`endif

// *** bmc_pkg.sv ***
`include "bmc_map.svh"

package bmc_pkg;

  // switching mode driven to an analog stage
  typedef enum logic [1:0] {SW_OFF, SW_PWM, SW_PFM, SW_APS} bmc_sw_mode_e;

  // chip-level operating state
  typedef enum logic [1:0] {G_BOOT, G_OFF, G_ON, G_SLEEP} bmc_gstate_e;

  // per-regulator start-up phase
  typedef enum logic [2:0] {PH_OFF, PH_WAIT, PH_SS_PFM, PH_SS_APS, PH_SS_PWM, PH_RUN} bmc_phase_e;

  typedef struct packed {
    bmc_gstate_e                                 gstate;
    bmc_phase_e [`BMC_NUM_REG-1:0]               phase;
    logic [`BMC_NUM_REG-1:0][`BMC_TMR_W-1:0]     tmr;
    logic [`BMC_SEQ_W-1:0]                       seq_cnt;
    logic [`BMC_NUM_REG-1:0][`BMC_MODE_W-1:0]    mode_code;
    logic [`BMC_NUM_REG-1:0]                     sleep_en;
    logic [`BMC_NUM_REG-1:0][`BMC_VOLT_W-1:0]    vout;
    bmc_sw_mode_e [`BMC_NUM_REG-1:0]             mode_o;
    logic [`BMC_NUM_REG-1:0]                     en_o;
    logic                                        loading;
    logic                                        load_boot;
    logic [4:0]                                  load_cnt;
    logic [1:0]                                  scan_idx;
    logic [1:0]                                  scan_prev;
    logic                                        stby_s1;
    logic                                        stby_s2;
    logic [`BMC_NUM_REG-1:0]                     pg_s1;
    logic [`BMC_NUM_REG-1:0]                     pg_s2;
  } bmc_state_s;

endpackage

// *** bmc_setpoint_mem.sv ***
`timescale 1ns/1ns
`default_nettype none

// small set-point store, registered read port
module bmc_setpoint_mem #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  // write port
  input  wire logic             wr_en_in,
  input  wire logic [AW-1:0]    wr_addr_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // read port
  input  wire logic [AW-1:0]    rd_addr_in,
  output logic      [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  initial
  begin
    if (DEPTH > (1 << AW) || WIDTH < 1)
      $error("bmc_setpoint_mem: depth does not fit address width");
  end

  // storage itself has no reset; the loader fills it at boot
  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
      mem_reg[wr_addr_in] <= wr_data_in;
  end

  // read data from a flip-flop, old data on a same-address collision
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      rd_data_out <= '0;
    else
      rd_data_out <= mem_reg[rd_addr_in];
  end

endmodule

`default_nettype wire

// *** bmc_buck_ctrl.sv ***
// Contract
// - at boot copy each fused default voltage into on, standby and sleep fields
// - after boot host writes set-point fields; each applies in its operating state
// - a fused setting merges buck one a and b into one regulator
// - switching mode changes on host write, standby, sleep and load variation
// - off mode disables the stage and turns on its discharge resistor
// - after turn-on each buck runs auto pulse-skip by default
// - soft-start steps forced PFM, then auto pulse-skip, then forced PWM
// - selected mode is applied 3.0 ms after output reaches regulation
// - codes 0000 off/off, 0001 PWM/off, 0011 PFM/off, 0100 AUTO_PULSE_SKIP_MODE/off
// - codes 0101 PWM/PWM, 0110 PWM/AUTO_PULSE_SKIP_MODE, 1100 AUTO_PULSE_SKIP_MODE/PFM, 1101 PWM/PFM
// - standby drives standby set point with the standby switching mode
// - leaving standby restores normal mode and normal set point
// - turn-off sleeps regulators with sleep-enable 1, turns off those with 0
// - sleep drives sleep set point in PFM; turn-on ends sleep
// - sleep to on: sleep-enabled regulators stay powered, go to normal settings
// - sleep to on: others restart in sequence with default voltage and mode
// - set points are five bits for one a/b, three for two, four for three
`timescale 1ns/1ns
`default_nettype none

`include "bmc_map.svh"

module bmc_buck_ctrl
  import bmc_pkg::*;
#(
  parameter int SETTLE_CYCLES = `BMC_SETTLE_CYCLES,
  parameter int SS_PFM_CYCLES = `BMC_SS_PFM_CYCLES,
  parameter int SEQ_STEP      = `BMC_SEQ_STEP
) (
  // clock and reset
  input  wire logic                                  clk_in,
  input  wire logic                                  resetn_in,
  // fused configuration
  input  wire logic [`BMC_NUM_REG*`BMC_VOLT_W-1:0]   fused_default_voltage_in,
  input  wire logic [`BMC_NUM_REG*`BMC_SLOT_W-1:0]   seq_slot_in,
  input  wire logic                                  merge_one_ab_in,
  // power-button and standby events
  input  wire logic                                  turn_on_event_in,
  input  wire logic                                  turn_off_event_in,
  input  wire logic                                  standby_pin_in,
  // host set-point and control writes
  input  wire logic                                  wr_en_in,
  input  wire logic [1:0]                            wr_sel_in,
  input  wire logic [1:0]                            wr_field_in,
  input  wire logic [`BMC_VOLT_W-1:0]                wr_data_in,
  output logic                                       busy_out,
  // analog stage feedback
  input  wire logic [`BMC_NUM_REG-1:0]               in_regulation_in,
  // analog stage control
  output logic [`BMC_NUM_REG-1:0]                    stage_enable_out,
  output logic [`BMC_NUM_REG-1:0]                    discharge_out,
  output logic [`BMC_NUM_REG*2-1:0]                  sw_mode_out,
  output logic [`BMC_NUM_REG*`BMC_VOLT_W-1:0]        vout_code_out,
  // status
  output logic [1:0]                                 op_state_out,
  output logic [`BMC_NUM_REG*`BMC_MODE_W-1:0]        mode_code_out,
  output logic [`BMC_NUM_REG-1:0]                    sleep_enable_out
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  initial
  begin
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << `BMC_TMR_W))
      $error("bmc_buck_ctrl: SETTLE_CYCLES out of range");
    if (SS_PFM_CYCLES < 1 || SS_PFM_CYCLES >= (1 << `BMC_TMR_W))
      $error("bmc_buck_ctrl: SS_PFM_CYCLES out of range");
    if (SEQ_STEP < 1 || SEQ_STEP * 8 >= (1 << `BMC_SEQ_W))
      $error("bmc_buck_ctrl: SEQ_STEP out of range");
  end

  // ****************************************************************
  // functions
  // ****************************************************************

  // valid voltage bits of a regulator
  function automatic logic [`BMC_VOLT_W-1:0] volt_mask(input logic [1:0] idx);
    case (idx)
      `BMC_IDX_TWO:   volt_mask = `BMC_MASK_TWO;
      `BMC_IDX_THREE: volt_mask = `BMC_MASK_THREE;
      default:        volt_mask = `BMC_MASK_ONE;
    endcase
  endfunction

  // switching mode in normal state
  function automatic bmc_sw_mode_e normal_mode(input logic [`BMC_MODE_W-1:0] code);
    case (code)
      `BMC_MODE_PWM_OFF, `BMC_MODE_PWM_PWM,
      `BMC_MODE_PWM_APS, `BMC_MODE_PWM_PFM: normal_mode = SW_PWM;
      `BMC_MODE_PFM_OFF:                    normal_mode = SW_PFM;
      `BMC_MODE_APS_OFF, `BMC_MODE_APS_APS,
      `BMC_MODE_APS_PFM:                    normal_mode = SW_APS;
      default:                              normal_mode = SW_OFF;
    endcase
  endfunction

  // switching mode in standby
  function automatic bmc_sw_mode_e standby_mode(input logic [`BMC_MODE_W-1:0] code);
    case (code)
      `BMC_MODE_PWM_PWM:                    standby_mode = SW_PWM;
      `BMC_MODE_PWM_APS, `BMC_MODE_APS_APS: standby_mode = SW_APS;
      `BMC_MODE_APS_PFM, `BMC_MODE_PWM_PFM: standby_mode = SW_PFM;
      default:                              standby_mode = SW_OFF;
    endcase
  endfunction

  // only documented codes are accepted
  function automatic logic mode_valid(input logic [`BMC_MODE_W-1:0] code);
    case (code)
      `BMC_MODE_OFF, `BMC_MODE_PWM_OFF, `BMC_MODE_PFM_OFF, `BMC_MODE_APS_OFF,
      `BMC_MODE_PWM_PWM, `BMC_MODE_PWM_APS, `BMC_MODE_APS_APS,
      `BMC_MODE_APS_PFM, `BMC_MODE_PWM_PFM: mode_valid = 1'b1;
      default:                              mode_valid = 1'b0;
    endcase
  endfunction

  // sequencer count at which a slot starts
  function automatic logic [`BMC_SEQ_W-1:0] slot_start(input logic [`BMC_SLOT_W-1:0] slot);
    slot_start = `BMC_SEQ_W'(int'(slot) * SEQ_STEP);
  endfunction

  localparam logic [`BMC_TMR_W-1:0] SETTLE_LOAD = `BMC_TMR_W'(SETTLE_CYCLES);
  localparam logic [`BMC_TMR_W-1:0] PFM_LOAD    = `BMC_TMR_W'(SS_PFM_CYCLES);

  // ****************************************************************
  // state, store and write port mux
  // ****************************************************************
  bmc_state_s            st_reg;
  bmc_state_s            st_next;

  logic                  mem_wr_en;
  logic [3:0]            mem_wr_addr;
  logic [`BMC_VOLT_W-1:0] mem_wr_data;
  logic [3:0]            mem_rd_addr;
  logic [`BMC_VOLT_W-1:0] mem_rd_data;
  logic [1:0]            ld_idx;
  logic [1:0]            ld_fld;
  logic                  ld_hit;
  logic                  host_ok;
  logic [1:0]            rd_fld;

  bmc_setpoint_mem #(
    .WIDTH (`BMC_VOLT_W),
    .DEPTH (16),
    .AW    (4)
  ) u_mem (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .wr_en_in    (mem_wr_en),
    .wr_addr_in  (mem_wr_addr),
    .wr_data_in  (mem_wr_data),
    .rd_addr_in  (mem_rd_addr),
    .rd_data_out (mem_rd_data)
  );

  // loader walks regulator/field pairs; at boot all three voltages,
  // on a sleep exit only the on field of regulators that were turned off
  always_comb
  begin
    ld_idx = st_reg.load_cnt[3:2];
    ld_fld = st_reg.load_cnt[1:0];
    ld_hit = st_reg.loading && (ld_fld != `BMC_FLD_CTRL) &&
             (st_reg.load_boot || (ld_fld == `BMC_FLD_ON && !st_reg.sleep_en[ld_idx]));
    // host writes refused while booting or reloading
    host_ok = wr_en_in && !st_reg.loading && st_reg.gstate != G_BOOT;
    if (ld_hit)
    begin
      mem_wr_en   = 1'b1;
      mem_wr_addr = st_reg.load_cnt[3:0];
      mem_wr_data = fused_default_voltage_in[ld_idx*`BMC_VOLT_W +: `BMC_VOLT_W]
                    & volt_mask(ld_idx);
    end
    else
    begin
      mem_wr_en   = host_ok && wr_field_in != `BMC_FLD_CTRL;
      mem_wr_addr = {wr_sel_in, wr_field_in};
      mem_wr_data = wr_data_in & volt_mask(wr_sel_in);
    end
  end

  // the scan picks the set point that the current state calls for
  always_comb
  begin
    if (st_reg.gstate == G_SLEEP && st_reg.sleep_en[st_reg.scan_idx])
      rd_fld = `BMC_FLD_SLEEP;
    else if (st_reg.stby_s2 && st_reg.gstate == G_ON)
      rd_fld = `BMC_FLD_STBY;
    else
      rd_fld = `BMC_FLD_ON;
    mem_rd_addr = {st_reg.scan_idx, rd_fld};
  end

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;

    // two-stage synchronisers for pins
    st_next.stby_s1 = standby_pin_in;
    st_next.stby_s2 = st_reg.stby_s1;
    st_next.pg_s1   = in_regulation_in;
    st_next.pg_s2   = st_reg.pg_s1;

    // set-point scan: one regulator per cycle, data one cycle later;
    // outputs hold their reset value during boot, the store is still unfilled
    st_next.scan_idx  = st_reg.scan_idx + 2'h1;
    st_next.scan_prev = st_reg.scan_idx;
    if (st_reg.gstate != G_BOOT)
      st_next.vout[st_reg.scan_prev] = mem_rd_data;

    // loader progress
    if (st_reg.loading)
    begin
      st_next.load_cnt = st_reg.load_cnt + 5'h1;
      if (st_reg.load_cnt == `BMC_LOAD_LAST - 5'h1)
      begin
        st_next.loading   = 1'b0;
        st_next.load_boot = 1'b0;
      end
    end

    // host control word; reserved codes leave the old mode in place
    if (host_ok && wr_field_in == `BMC_FLD_CTRL)
    begin
      st_next.sleep_en[wr_sel_in] = wr_data_in[`BMC_CTRL_SE_BIT];
      if (mode_valid(wr_data_in[`BMC_MODE_W-1:0]))
        st_next.mode_code[wr_sel_in] = wr_data_in[`BMC_MODE_W-1:0];
    end

    // sequencer counter saturates
    if (st_reg.seq_cnt != {`BMC_SEQ_W{1'b1}})
      st_next.seq_cnt = st_reg.seq_cnt + `BMC_SEQ_W'(1);

    // chip-level state
    case (st_reg.gstate)
      G_BOOT:
      begin
        if (!st_reg.loading)
          st_next.gstate = G_OFF;
      end
      G_OFF:
      begin
        if (turn_on_event_in)
        begin
          st_next.gstate  = G_ON;
          st_next.seq_cnt = '0;
          for (int i = 0; i < `BMC_NUM_REG; i++)
            st_next.phase[i] = PH_WAIT;
        end
      end
      G_ON:
      begin
        if (turn_off_event_in)
        begin
          st_next.gstate = G_SLEEP;
          for (int i = 0; i < `BMC_NUM_REG; i++)
          begin
            if (!st_reg.sleep_en[i])
              st_next.phase[i] = PH_OFF;
          end
        end
      end
      G_SLEEP:
      begin
        if (turn_on_event_in)
        begin
          st_next.gstate    = G_ON;
          st_next.seq_cnt   = '0;
          st_next.loading   = 1'b1;
          st_next.load_boot = 1'b0;
          st_next.load_cnt  = '0;
          for (int i = 0; i < `BMC_NUM_REG; i++)
          begin
            if (!st_reg.sleep_en[i])
            begin
              st_next.phase[i]     = PH_WAIT;
              st_next.mode_code[i] = `BMC_MODE_RESET;
            end
          end
        end
      end
      default:
        st_next.gstate = G_BOOT;
    endcase

    // per-regulator soft-start
    for (int i = 0; i < `BMC_NUM_REG; i++)
    begin
      case (st_reg.phase[i])
        PH_OFF:
          st_next.tmr[i] = '0;
        PH_WAIT:
        begin
          // waits for its slot in the start-up sequence
          if (st_reg.gstate == G_ON &&
              st_reg.seq_cnt >= slot_start(seq_slot_in[i*`BMC_SLOT_W +: `BMC_SLOT_W]))
          begin
            if (normal_mode(st_reg.mode_code[i]) == SW_OFF)
              st_next.phase[i] = PH_OFF;
            else
            begin
              st_next.phase[i] = PH_SS_PFM;
              st_next.tmr[i]   = PFM_LOAD;
            end
          end
        end
        PH_SS_PFM:
        begin
          st_next.tmr[i] = st_reg.tmr[i] - `BMC_TMR_W'(1);
          if (st_reg.tmr[i] == `BMC_TMR_W'(1))
            st_next.phase[i] = PH_SS_APS;
        end
        PH_SS_APS:
        begin
          if (st_reg.pg_s2[i])
          begin
            st_next.phase[i] = PH_SS_PWM;
            st_next.tmr[i]   = SETTLE_LOAD;
          end
        end
        PH_SS_PWM:
        begin
          st_next.tmr[i] = st_reg.tmr[i] - `BMC_TMR_W'(1);
          if (st_reg.tmr[i] == `BMC_TMR_W'(1))
            st_next.phase[i] = PH_RUN;
        end
        PH_RUN:
          st_next.tmr[i] = '0;
        default:
          st_next.phase[i] = PH_OFF;
      endcase
    end

    // stage mode: soft-start steps, then sleep, standby or normal
    for (int i = 0; i < `BMC_NUM_REG; i++)
    begin
      case (st_reg.phase[i])
        PH_SS_PFM: st_next.mode_o[i] = SW_PFM;
        PH_SS_APS: st_next.mode_o[i] = SW_APS;
        PH_SS_PWM: st_next.mode_o[i] = SW_PWM;
        PH_RUN:
        begin
          if (st_reg.gstate == G_SLEEP)
            st_next.mode_o[i] = SW_PFM;
          else if (st_reg.stby_s2)
            st_next.mode_o[i] = standby_mode(st_reg.mode_code[i]);
          else
            st_next.mode_o[i] = normal_mode(st_reg.mode_code[i]);
        end
        default:   st_next.mode_o[i] = SW_OFF;
      endcase
    end

    // merged pair: buck one b follows buck one a exactly
    if (merge_one_ab_in)
    begin
      st_next.mode_o[`BMC_IDX_ONE_B] = st_next.mode_o[`BMC_IDX_ONE_A];
      st_next.vout[`BMC_IDX_ONE_B]   = st_next.vout[`BMC_IDX_ONE_A];
    end

    // stage enable follows the mode; off also means discharge
    for (int i = 0; i < `BMC_NUM_REG; i++)
      st_next.en_o[i] = st_next.mode_o[i] != SW_OFF;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      st_reg           <= '0;
      st_reg.gstate    <= G_BOOT;
      st_reg.loading   <= 1'b1;
      st_reg.load_boot <= 1'b1;
      for (int i = 0; i < `BMC_NUM_REG; i++)
      begin
        st_reg.phase[i]     <= PH_OFF;
        st_reg.mode_o[i]    <= SW_OFF;
        st_reg.mode_code[i] <= `BMC_MODE_RESET;
      end
    end
    else
      st_reg <= st_next;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // auto pulse-skip covers load variation inside the analog stage
  always_comb
  begin
    for (int i = 0; i < `BMC_NUM_REG; i++)
    begin
      sw_mode_out[i*2 +: 2]                       = st_reg.mode_o[i];
      vout_code_out[i*`BMC_VOLT_W +: `BMC_VOLT_W] = st_reg.vout[i];
      mode_code_out[i*`BMC_MODE_W +: `BMC_MODE_W] = st_reg.mode_code[i];
    end
  end

  assign stage_enable_out = st_reg.en_o;
  assign discharge_out    = ~st_reg.en_o;
  assign sleep_enable_out = st_reg.sleep_en;
  assign op_state_out     = st_reg.gstate;
  assign busy_out         = st_reg.loading || st_reg.gstate == G_BOOT;

endmodule

`default_nettype wire

// *** bmc_buck_ctrl_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// port-level checks of the mode control
// ****************************************
module bmc_buck_ctrl_checker (
  // events, host port and status
  input wire logic        clk_in, resetn_in, merge_one_ab_in, turn_on_event_in, turn_off_event_in,
  input wire logic        wr_en_in, busy_out,
  input wire logic [1:0]  wr_sel_in, wr_field_in, op_state_out,
  input wire logic [4:0]  wr_data_in,
  input wire logic [3:0]  stage_enable_out, discharge_out, sleep_enable_out,
  input wire logic [7:0]  sw_mode_out,
  input wire logic [19:0] vout_code_out,
  input wire logic [15:0] mode_code_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // the load must finish in bounded time, defaults must already stand
  a_boot_done: assert property ($rose(resetn_in) |-> (busy_out && mode_code_out == 16'h8888
    && sleep_enable_out == 4'h0) ##[14:20] (op_state_out == 2'h1 && !busy_out)) else $error("boot load");
  a_off_discharge: assert property (discharge_out == ~stage_enable_out) else $error("discharge");
  a_turn_on: assert property (turn_on_event_in && op_state_out[0] |=> op_state_out == 2'h2)
    else $error("turn-on");
  a_turn_off: assert property (turn_off_event_in && op_state_out == 2'h2 |=> op_state_out == 2'h3)
    else $error("turn-off");
  a_sleep_stage: assert property (op_state_out == 2'h3 [*3] ##0 $stable(sleep_enable_out)
    |-> stage_enable_out[3:2] == sleep_enable_out[3:2]) else $error("sleep stage");
  // a lagging mirror would show up while merged for a few cycles
  a_merge_mirror: assert property (merge_one_ab_in [*4] |-> stage_enable_out[1] == stage_enable_out[0]
    && sw_mode_out[3:2] == sw_mode_out[1:0]) else $error("merge mirror");
  a_volt_width: assert property (vout_code_out[14:13] == 2'h0 && !vout_code_out[19])
    else $error("voltage width");
  a_ss_pfm_first: assert property ($rose(stage_enable_out[3]) |-> ##[0:1] sw_mode_out[7:6] == 2'h2)
    else $error("soft-start");
  a_ctrl_write: assert property (wr_en_in && !busy_out && wr_field_in == 2'h3 && wr_sel_in == 2'h3
    |=> sleep_enable_out[3] == $past(wr_data_in[4])) else $error("control write");
  a_reserved_kept: assert property (wr_en_in && !busy_out && wr_field_in == 2'h3 && wr_sel_in == 2'h3
    && wr_data_in[3:0] == 4'h2 |=> $stable(mode_code_out[15:12])) else $error("reserved code");
endmodule
`default_nettype wire

// *** bmc_stage_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module bmc_stage_model (
  // control from the block
  input  wire logic       clk_in,
  input  wire logic [3:0] en_in,
  input  wire logic       slow_in,
  // regulation flags back
  output logic      [3:0] in_reg_out
);
  int cnt [4];
  // flag drops on the first clock edge that sees the enable low, so a restart always sees a fresh ramp
  always_ff @(posedge clk_in)
    for (int i = 0; i < 4; i++)
    begin
      cnt[i] <= en_in[i] ? cnt[i] + 1 : 0;
      in_reg_out[i] <= en_in[i] && cnt[i] >= (slow_in ? 40 : 12);
    end
endmodule
`default_nettype wire

// *** bmc_buck_ctrl_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module bmc_buck_ctrl_tb_top;
  localparam logic [19:0] FUSE = {5'h0c, 5'h05, 5'h0a, 5'h15};
  logic clk_in = 0, resetn_in = 0, merge_one_ab_in = 0, turn_on_event_in = 0, turn_off_event_in = 0;
  logic standby_pin_in = 0, wr_en_in = 0, slow = 0, busy_out;
  logic [1:0] wr_sel_in = 0, wr_field_in = 0, op_state_out;
  logic [4:0] wr_data_in = 0;
  logic [19:0] fused_default_voltage_in = FUSE, vout_code_out;
  logic [11:0] seq_slot_in = 12'h000;
  logic [3:0] in_regulation_in, stage_enable_out, discharge_out, sleep_enable_out;
  logic [7:0] sw_mode_out;
  logic [15:0] mode_code_out;
  logic [3:0] cd [9] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'hc, 4'hd, 4'h2, 4'h0};
  logic [1:0] em [9] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h1, 2'h3, 2'h1, 2'h1, 2'h0};
  int err_total = 0, comparisons = 0, n;
  // short counts keep soft-start walks to a few dozen cycles
  bmc_buck_ctrl #(.SETTLE_CYCLES(20), .SS_PFM_CYCLES(4), .SEQ_STEP(4)) DUT (.clk_in, .resetn_in,
    .fused_default_voltage_in, .seq_slot_in, .merge_one_ab_in, .turn_on_event_in, .turn_off_event_in,
    .standby_pin_in, .wr_en_in, .wr_sel_in, .wr_field_in, .wr_data_in, .busy_out, .in_regulation_in,
    .stage_enable_out, .discharge_out, .sw_mode_out, .vout_code_out, .op_state_out, .mode_code_out,
    .sleep_enable_out);
  bmc_stage_model u_stage (.clk_in, .en_in(stage_enable_out), .slow_in(slow), .in_reg_out(in_regulation_in));
  initial forever #5 clk_in = ~clk_in;
  // ****************************************
  // helpers
  // ****************************************
  task automatic cyc(input int k); repeat (k) @(negedge clk_in); endtask
  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tmo(); err_total++; $display("[FAIL] wait expected done seen timeout"); results(); endtask
  task automatic wr(input logic [1:0] s, f, input logic [4:0] d);
    @(negedge clk_in); {wr_en_in, wr_sel_in, wr_field_in, wr_data_in} = {1'h1, s, f, d};
    @(negedge clk_in); wr_en_in = 0;
  endtask
  task automatic ev(input bit on);
    @(negedge clk_in); {turn_on_event_in, turn_off_event_in} = {on, !on};
    @(negedge clk_in); {turn_on_event_in, turn_off_event_in} = 2'h0;
  endtask
  // counts cycles until buck three shows the wanted mode
  task automatic wm(input logic [1:0] m);
    for (n = 0; sw_mode_out[7:6] !== m; n++)
    begin
      if (n > 400) tmo();
      cyc(1);
    end
  endtask
  task automatic ss(); wm(2'h2); wm(2'h3); wm(2'h1); wm(2'h3); chk("settle", 1, n >= 19 && n <= 22); endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_boot();
    for (n = 0; busy_out !== 1'h0; n++)
    begin
      if (n > 100) tmo();
      cyc(1);
    end
    chk("state", 1, op_state_out);
    chk("mode_code", 16'h8888, mode_code_out);
    chk("discharge", 4'hf, discharge_out);
  endtask
  task automatic t_on();
    ev(1); cyc(1); chk("state", 2, op_state_out);
    ss(); cyc(4);
    chk("vout", FUSE, vout_code_out);
    chk("sw_mode", 8'hff, sw_mode_out);
  endtask
  task automatic t_stby();
    wr(2, 3, 5'h06); wr(2, 0, 5'h1f); cyc(8);
    chk("vout2", 7, vout_code_out[14:10]);
    standby_pin_in = 1; cyc(8);
    chk("sw2", 3, sw_mode_out[5:4]); chk("vout2", 5, vout_code_out[14:10]);
    standby_pin_in = 0; cyc(8);
    chk("sw2", 1, sw_mode_out[5:4]); chk("vout2", 7, vout_code_out[14:10]);
  endtask
  task automatic t_codes();
    for (int i = 0; i < 9; i++)
    begin
      wr(3, 3, {1'h0, cd[i]}); cyc(3);
      chk("sw3", em[i], sw_mode_out[7:6]);
      chk("code3", cd[i] == 4'h2 ? 4'hd : cd[i], mode_code_out[15:12]);
    end
    chk("discharge3", 1, discharge_out[3]);
  endtask
  task automatic t_merge();
    merge_one_ab_in = 1; wr(0, 0, 5'h11); cyc(8);
    chk("vout_b", 5'h11, vout_code_out[9:5]);
    merge_one_ab_in = 0; cyc(8);
  endtask
  task automatic t_sleep();
    wr(2, 3, 5'h16); wr(2, 2, 5'h1a); ev(0); cyc(8);
    chk("state", 3, op_state_out); chk("enable", 4'h4, stage_enable_out);
    chk("sw2", 2, sw_mode_out[5:4]); chk("vout2", 2, vout_code_out[14:10]);
    // the forced PFM step of buck three is short, so catch it right after the event
    slow = 1; ev(1); wm(2'h2);
    chk("sw2", 1, sw_mode_out[5:4]);
    chk("code3", 8, mode_code_out[15:12]);
    ss(); chk("vout2", 7, vout_code_out[14:10]);
    chk("vout3", 5'h0c, vout_code_out[19:15]);
    chk("vout0", 5'h15, vout_code_out[4:0]);
  endtask
  initial
  begin
    cyc(12);
    resetn_in = 1;
    t_boot(); t_on(); t_stby(); t_codes(); t_merge(); t_sleep();
    results();
  end
endmodule
bind bmc_buck_ctrl bmc_buck_ctrl_checker u_chk (.clk_in, .resetn_in, .merge_one_ab_in, .turn_on_event_in,
  .turn_off_event_in, .wr_en_in, .busy_out, .wr_sel_in, .wr_field_in, .op_state_out, .wr_data_in,
  .stage_enable_out, .discharge_out, .sleep_enable_out, .sw_mode_out, .vout_code_out, .mode_code_out);
`default_nettype wire
